// ---- opvs_pkg.sv ----
// Package: constants shared by the one-pin voltage scaling receiver
package opvs_pkg;

  // ==========================================================
  // Clock and timebase
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_DIV = TICK_NS / CLK_PERIOD_NS;
  // Longest times round down to whole ticks
  localparam int unsigned T_TIMEOUT_US = 520;
  localparam int unsigned TIMEOUT_TICKS = T_TIMEOUT_US * 1000 / TICK_NS;
  localparam int unsigned T_ACK_US = 520;
  localparam int unsigned ACK_TICKS = T_ACK_US * 1000 / TICK_NS;
  // Least time rounds up to whole ticks
  localparam int unsigned T_VALACK_US = 2;
  localparam int unsigned VALACK_TICKS = (T_VALACK_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned TK_W = 12;

  // ==========================================================
  // Frame layout
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned ACK_REQ_POS = 7;
  localparam int unsigned SEL_HI_POS = 6;
  localparam int unsigned SEL_LO_POS = 5;
  localparam int unsigned CODE_W = 5;
  localparam logic [1:0] SEL_CONV1 = 2'h0;
  localparam logic [1:0] SEL_CONV2 = 2'h2;
  localparam logic [7:0] DEV_ADDR_DEF = 8'h5a; // Arbitrary value
  localparam logic [CODE_W-1:0] CODE_RST = 5'h00;

  // ==========================================================
  // Register map
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_CONV1 = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_CONV2 = 4'hc;
  localparam int unsigned CTRL_EN_POS = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OPVS_RX = 2'h1,
    OPVS_ACK = 2'h2
  } opvs_state_e;

endpackage : opvs_pkg

// ---- opvs_bit_if.sv ----
// Interface: decoded bits from the pulse decoder to the frame logic
interface opvs_bit_if;
  logic restart; // Disarm decoder, next fall starts a bit
  logic bit_stb; // One-cycle pulse per decoded bit
  logic bit_one; // Bit value
  logic bit_bad; // Ratio fits neither one nor zero
  modport dec (input restart, output bit_stb, output bit_one, output bit_bad);
  modport core (output restart, input bit_stb, input bit_one, input bit_bad);
endinterface : opvs_bit_if

// ---- opvs_tick_div.sv ----
// Module: timebase divider giving a one-cycle tick enable
module opvs_tick_div #(
  parameter int unsigned DIV = opvs_pkg::TICK_DIV // Cycles per tick
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, active low
  output logic tick // One-cycle enable
);
  logic [15:0] cnt_r;

  // ==========================================================
  // Free-running divider
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_r == 16'(DIV - 1)) begin
      cnt_r <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule : opvs_tick_div

// ---- opvs_bit_dec.sv ----
// Module: pulse-ratio bit decoder on the mode/data pin
module opvs_bit_dec #(
  parameter int unsigned CNT_W = opvs_pkg::CNT_W // Pulse counter width
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic pin, // Mode/data pin level
  opvs_bit_if.dec bus // Decoded bits
);
  localparam logic [CNT_W-1:0] CMAX = '1;
  logic pin_d_r;
  logic armed_r;
  logic [CNT_W-1:0] low_r;
  logic [CNT_W-1:0] high_r;
  logic fall;
  logic is_one;
  logic is_zero;

  assign fall = pin_d_r & ~pin;
  // Ratio test on the bit just closed; counters saturate on slow masters
  assign is_one = {1'b0, high_r} >= {low_r, 1'b0};
  assign is_zero = {1'b0, low_r} >= {high_r, 1'b0};

  // ==========================================================
  // Low and high time of the current bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_d_r <= 1'b1;
      low_r <= '0;
      high_r <= '0;
    end else begin
      pin_d_r <= pin;
      if (fall) begin
        low_r <= {{(CNT_W-1){1'b0}}, 1'b1};
        high_r <= '0;
      end else if (pin) begin
        if (high_r != CMAX) high_r <= high_r + 1'b1;
      end else if (low_r != CMAX) begin
        low_r <= low_r + 1'b1;
      end
    end
  end

  // ==========================================================
  // Each fall opens a bit; an armed fall also closes the one before
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      armed_r <= 1'b0;
      bus.bit_stb <= 1'b0;
      bus.bit_one <= 1'b0;
      bus.bit_bad <= 1'b0;
    end else begin
      bus.bit_stb <= fall & armed_r & ~bus.restart;
      bus.bit_one <= is_one;
      bus.bit_bad <= ~is_one & ~is_zero;
      if (bus.restart) armed_r <= 1'b0;
      else if (fall) armed_r <= 1'b1;
    end
  end
endmodule : opvs_bit_dec

// ---- opvs_core.sv ----
// Module: one-pin voltage scaling receiver with AXI4-Lite registers
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
module opvs_core #(
  parameter int unsigned TICK_DIV = opvs_pkg::TICK_DIV, // Cycles per tick
  parameter int unsigned TIMEOUT_TICKS = opvs_pkg::TIMEOUT_TICKS, // Power-save timeout
  parameter int unsigned ACK_TICKS = opvs_pkg::ACK_TICKS, // Ack pulse length
  parameter int unsigned VALACK_TICKS = opvs_pkg::VALACK_TICKS, // Validation delay
  parameter logic [7:0] DEV_ADDR = opvs_pkg::DEV_ADDR_DEF, // Own address, arbitrary
  parameter int unsigned CNT_W = opvs_pkg::CNT_W // Pulse counter width
) (
  input wire logic clk, // 200 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire logic mode_data, // Mode/data pin level
  output logic ack_out, // Pin drive value, always low
  output logic ack_oe, // Pulldown enable
  output logic force_pwm, // 1 fixed-frequency, 0 power-save
  output logic [opvs_pkg::CODE_W-1:0] conv1_voltage_code, // Converter 1 code
  output logic [opvs_pkg::CODE_W-1:0] conv2_voltage_code, // Converter 2 code
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [opvs_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte strobes
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  output logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  input wire logic [opvs_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp // Read response
);
  localparam int unsigned AW = opvs_pkg::ADDR_W;
  localparam int unsigned TK_W = opvs_pkg::TK_W;
  localparam logic [TK_W-1:0] TO_LIM = TK_W'(TIMEOUT_TICKS);
  localparam logic [TK_W-1:0] VA_LIM = TK_W'(VALACK_TICKS);
  localparam logic [TK_W-1:0] AK_LIM = TK_W'(ACK_TICKS);
  localparam logic [4:0] FB = 5'(opvs_pkg::FRAME_BITS);
  localparam logic [4:0] ADDR_LAST = 5'(opvs_pkg::BYTE_BITS - 1);

  opvs_bit_if bif ();
  logic tick;
  opvs_pkg::opvs_state_e state_r;
  logic en_r;
  logic last_ok_r;
  logic [TK_W-1:0] low_ticks_r;
  logic [TK_W-1:0] ack_ticks_r;
  logic [4:0] bit_cnt_r;
  logic skip_r;
  logic bad_r;
  logic [15:0] shift_r;
  logic in_rx;
  logic timeout_hit;
  logic valid_hit;
  logic ack_end;
  logic frame_ok;
  logic ack_fire;
  logic [7:0] rx_addr;
  logic [1:0] rx_sel;
  logic [opvs_pkg::CODE_W-1:0] rx_code;

  opvs_tick_div #(.DIV(TICK_DIV)) u_div (
    .clk(clk),
    .rstn(rstn),
    .tick(tick)
  );

  opvs_bit_dec #(.CNT_W(CNT_W)) u_dec (
    .clk(clk),
    .rstn(rstn),
    .pin(mode_data),
    .bus(bif)
  );

  // ==========================================================
  // Frame fields and events
  assign rx_addr = shift_r[15:8];
  assign rx_sel = {shift_r[opvs_pkg::SEL_HI_POS], shift_r[opvs_pkg::SEL_LO_POS]};
  assign rx_code = shift_r[opvs_pkg::CODE_W-1:0];
  assign in_rx = (state_r == opvs_pkg::OPVS_RX);
  assign timeout_hit = in_rx & tick & ~mode_data & (low_ticks_r == TO_LIM - 1'b1);
  // Tick phase makes the validation delay up to one tick short of exact
  assign valid_hit = in_rx & tick & ~mode_data & (bit_cnt_r == FB)
    & (low_ticks_r == VA_LIM - 1'b1);
  assign ack_end = ~in_rx & tick & (ack_ticks_r == AK_LIM - 1'b1);
  assign frame_ok = ~bad_r & en_r & (rx_addr == DEV_ADDR);
  assign ack_fire = valid_hit & frame_ok & shift_r[opvs_pkg::ACK_REQ_POS];
  // Disarm so the mode-change fall or the ack release opens a fresh bit
  assign bif.restart = timeout_hit | valid_hit | ack_end;

  // ==========================================================
  // Low-time counter; held clear while we drive the ack ourselves
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_ticks_r <= '0;
    end else if (mode_data || !in_rx) begin
      low_ticks_r <= '0;
    end else if (tick && low_ticks_r != TO_LIM) begin
      low_ticks_r <= low_ticks_r + 1'b1;
    end
  end

  // ==========================================================
  // Operating mode; only a timeout leaves fixed-frequency mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      force_pwm <= 1'b0;
    end else if (mode_data) begin
      force_pwm <= 1'b1;
    end else if (timeout_hit) begin
      force_pwm <= 1'b0;
    end
  end

  // ==========================================================
  // Bit assembly; the pair after the address byte is end plus start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_r <= 5'h00;
      skip_r <= 1'b0;
      bad_r <= 1'b0;
      shift_r <= 16'h0000;
    end else if (!in_rx || timeout_hit || valid_hit) begin
      bit_cnt_r <= 5'h00;
      skip_r <= 1'b0;
      bad_r <= 1'b0;
    end else if (bif.bit_stb) begin
      if (skip_r) begin
        skip_r <= 1'b0;
      end else if (bit_cnt_r == FB) begin
        bad_r <= 1'b1;
      end else begin
        shift_r <= {shift_r[14:0], bif.bit_one};
        bit_cnt_r <= bit_cnt_r + 5'h01;
        if (bif.bit_bad) bad_r <= 1'b1;
        if (bit_cnt_r == ADDR_LAST) skip_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Voltage code registers, written only by a good frame
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      conv1_voltage_code <= opvs_pkg::CODE_RST;
      conv2_voltage_code <= opvs_pkg::CODE_RST;
      last_ok_r <= 1'b0;
    end else if (valid_hit) begin
      last_ok_r <= frame_ok;
      if (frame_ok && rx_sel == opvs_pkg::SEL_CONV1) conv1_voltage_code <= rx_code;
      if (frame_ok && rx_sel == opvs_pkg::SEL_CONV2) conv2_voltage_code <= rx_code;
    end
  end

  // ==========================================================
  // Acknowledge sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= opvs_pkg::OPVS_RX;
      ack_oe <= 1'b0;
      ack_ticks_r <= '0;
    end else begin
      case (state_r)
        opvs_pkg::OPVS_RX: begin
          if (ack_fire) begin
            state_r <= opvs_pkg::OPVS_ACK;
            ack_oe <= 1'b1;
            ack_ticks_r <= '0;
          end
        end
        opvs_pkg::OPVS_ACK: begin
          if (ack_end) begin
            state_r <= opvs_pkg::OPVS_RX;
            ack_oe <= 1'b0;
          end else if (tick) begin
            ack_ticks_r <= ack_ticks_r + 1'b1;
          end
        end
        default: begin
          state_r <= opvs_pkg::OPVS_RX;
          ack_oe <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: the pin is only ever pulled low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ack_out <= 1'b0;
    else ack_out <= 1'b0;
  end

  // ==========================================================
  // AXI4-Lite slave
  function automatic logic reg_mapped(input logic [AW-1:0] a);
    reg_mapped = (a == opvs_pkg::OFF_CTRL) || (a == opvs_pkg::OFF_STATUS)
      || (a == opvs_pkg::OFF_CONV1) || (a == opvs_pkg::OFF_CONV2);
  endfunction : reg_mapped

  logic aw_got_r;
  logic w_got_r;
  logic [AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic do_write;
  logic [31:0] rd_data;

  assign do_write = aw_got_r & w_got_r & ~s_axi_bvalid;

  // Address and data taken in either order, response after both
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= opvs_pkg::RESP_OKAY;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb0_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_mapped(awaddr_r) ? opvs_pkg::RESP_OKAY : opvs_pkg::RESP_SLVERR;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Interface enable; cleared, frames decode but write no code and give no ack
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) en_r <= opvs_pkg::CTRL_EN_RST;
    else if (do_write && awaddr_r == opvs_pkg::OFF_CTRL && wstrb0_r) begin
      en_r <= wdata_r[opvs_pkg::CTRL_EN_POS];
    end
  end

  // Read data mux
  always_comb begin
    rd_data = 32'h00000000;
    if (s_axi_araddr == opvs_pkg::OFF_CTRL) begin
      rd_data[0] = en_r;
    end else if (s_axi_araddr == opvs_pkg::OFF_STATUS) begin
      rd_data[3:0] = {(bit_cnt_r != 5'h00), last_ok_r, ack_oe, force_pwm};
    end else if (s_axi_araddr == opvs_pkg::OFF_CONV1) begin
      rd_data[opvs_pkg::CODE_W-1:0] = conv1_voltage_code;
    end else if (s_axi_araddr == opvs_pkg::OFF_CONV2) begin
      rd_data[opvs_pkg::CODE_W-1:0] = conv2_voltage_code;
    end
  end

  // Read channel, one read at a time
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= opvs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= reg_mapped(s_axi_araddr) ? opvs_pkg::RESP_OKAY : opvs_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic ack_cause;
  assign ack_cause = valid_hit & ~bad_r & (rx_addr == DEV_ADDR) & shift_r[opvs_pkg::ACK_REQ_POS];

  // Sampled reset keeps the release edge, still in reset for the flops, out
  a_pwm_on_high: assert property (rstn && mode_data |=> force_pwm)
    else $error("high pin did not force fixed frequency");
  a_pwm_in_frame: assert property (bit_cnt_r != 5'h00 |-> force_pwm)
    else $error("power save during frame");
  a_timeout_ps: assert property (timeout_hit |=> !force_pwm && bit_cnt_r == 5'h00)
    else $error("timeout did not enter power save");
  a_ack_cause: assert property ($rose(ack_oe) |-> $past(ack_cause))
    else $error("ack without request or match");
  a_ack_drive_low: assert property (ack_oe |-> !ack_out)
    else $error("ack drives high");
  a_ack_length: assert property (ack_oe |-> ack_ticks_r < AK_LIM)
    else $error("ack too long");
  a_ack_release: assert property (ack_end |=> !ack_oe ##1 !ack_oe)
    else $error("ack not released");
  a_conv1_cause: assert property ($changed(conv1_voltage_code) |->
    $past(valid_hit) && !$past(bad_r) && $past(rx_sel) == opvs_pkg::SEL_CONV1)
    else $error("conv1 code written without good frame");
  a_bit_bound: assert property (bit_cnt_r <= FB)
    else $error("bit count overflow");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  c_ack_given: cover property ($rose(ack_oe));
  c_conv2_write: cover property ($changed(conv2_voltage_code));
  c_timeout: cover property (timeout_hit);
  c_bad_frame: cover property (valid_hit && !frame_ok);
endmodule : opvs_core

// ---- opvs_pin_master.sv ----
// Partner model: open-drain master driving frames onto the mode/data line
module opvs_pin_master (
  input wire logic clk, // System clock
  output logic pull_low // High while the master pulls the line low
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy; // Frame in progress

  // =====
  // Idle: released, the pull-up holds the line high
  initial begin
    pull_low = 1'b0;
    busy = 1'b0;
  end

  // One level segment, entered and left just after a rising edge
  task seg(input logic lo, input int n);
    pull_low <= lo;
    repeat (n) @(posedge clk);
  endtask : seg

  // Ones high 3x low, zeros low 3x high, bad bits 1:1
  task send_bit(input logic v, input logic bad);
    int lo;
    lo = bad ? 8 : (v ? 4 : 12);
    seg(1'b1, lo);
    seg(1'b0, 16 - lo);
  endtask : send_bit

  // Address byte, end/start pair, data byte, then low through validation
  task send_frame(input logic [7:0] a, input logic [7:0] d, input int bad_idx);
    logic [15:0] fr;
    fr = {a, d};
    busy <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      if (i == 7) begin
        seg(1'b1, 12); // End of stream
        seg(1'b0, 4); // Start condition
      end
      send_bit(fr[i], i == bad_idx);
    end
    seg(1'b1, 14); // Held low until the answer is valid
    pull_low <= 1'b0; // Release only, never drive high
    busy <= 1'b0;
  endtask : send_frame
endmodule : opvs_pin_master

// ---- opvs_core_tb_top.sv ----
// Testbench: pin frames and register accesses for the voltage scaling receiver
module opvs_core_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TD = 4;
  localparam int TO = 40;
  localparam int AT = 10;
  localparam logic [7:0] DA = opvs_pkg::DEV_ADDR_DEF;
  logic clk, rstn, pull_low, mode_data, ack_out, ack_oe, force_pwm, pwm_drop, od_bad;
  logic [opvs_pkg::CODE_W-1:0] c1, c2;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int n_mismatch, comparisons, ack_len;

  // =====
  // Open-drain wire: low when either side pulls, else the pull-up wins
  assign mode_data = !(pull_low || (ack_oe && !ack_out));

  opvs_pin_master m (.clk(clk), .pull_low(pull_low));

  opvs_core #(.TICK_DIV(TD), .TIMEOUT_TICKS(TO), .ACK_TICKS(AT), .VALACK_TICKS(2)) dut (
    .clk(clk), .rstn(rstn), .mode_data(mode_data), .ack_out(ack_out), .ack_oe(ack_oe),
    .force_pwm(force_pwm), .conv1_voltage_code(c1), .conv2_voltage_code(c2),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Pulse length and sticky flags; sampled values are pre-edge
  always @(posedge clk) begin
    if (ack_oe === 1'b1) ack_len <= ack_len + 1;
    if (ack_oe === 1'b1 && ack_out !== 1'b0) od_bad <= 1'b1;
    if (m.busy && force_pwm !== 1'b1) pwm_drop <= 1'b1;
  end

  // =====
  // Compare and report
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Verdict and end of run
  task results();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // AXI4-Lite write: AW and W together, each dropped once taken, then B
  task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    @(posedge clk);
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end while (!(bvalid === 1'b1 && !aw && !w)); // Only the watchdog ends a hang
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(er));
  endtask : axi_wr

  // AXI4-Lite read with a mask on the returned word
  task axi_rd(input logic [3:0] a, input logic [31:0] msk, exp, input logic [1:0] er);
    logic ar;
    @(posedge clk);
    ar = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (ar && arready === 1'b1) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
    end while (!(rvalid === 1'b1 && !ar)); // Only the watchdog ends a hang
    rready <= 1'b0;
    chk("rdata", rdata & msk, exp);
    chk("rresp", 32'(rresp), 32'(er));
  endtask : axi_rd

  // One frame, then pulse length and code outputs
  task fchk(input logic [7:0] a, d, input int bad, input logic ack, input logic [4:0] e1, e2);
    int s, n;
    logic ok;
    s = ack_len;
    m.send_frame(a, d, bad);
    repeat (AT * TD + 20) @(posedge clk);
    n = ack_len - s;
    ok = ack ? (n >= (AT - 1) * TD && n <= AT * TD + 1) : (n == 0);
    chk("ack_pulse", 32'(ok), 32'h1);
    chk("conv1", 32'(c1), 32'(e1));
    chk("conv2", 32'(c2), 32'(e2));
    chk("force_pwm", 32'(force_pwm), 32'h1);
  endtask : fchk

  // =====
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, pwm_drop, od_bad} = 7'h00;
    {awaddr, araddr, wdata} = 40'h0;
    wstrb = 4'hf;
    n_mismatch = 0;
    comparisons = 0;
    ack_len = 0;
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    chk("rst_out", 32'({ack_oe, force_pwm, c1, c2}), 32'h0);
    rstn <= 1'b1;
    axi_rd(opvs_pkg::OFF_CTRL, 32'h1, 32'h1, opvs_pkg::RESP_OKAY);
    axi_rd(4'h2, 32'hffffffff, 32'h0, opvs_pkg::RESP_SLVERR);
    axi_wr(4'h6, 32'h1, opvs_pkg::RESP_SLVERR);
    axi_wr(opvs_pkg::OFF_CONV1, 32'h1f, opvs_pkg::RESP_OKAY);
    axi_rd(opvs_pkg::OFF_CONV1, 32'h1f, 32'h0, opvs_pkg::RESP_OKAY);
    axi_rd(opvs_pkg::OFF_STATUS, 32'hf, 32'h1, opvs_pkg::RESP_OKAY);
    fchk(DA, 8'h95, -1, 1'b1, 5'h15, 5'h00);
    fchk(DA, 8'h4a, -1, 1'b0, 5'h15, 5'h0a);
    fchk(DA, 8'hbf, -1, 1'b1, 5'h15, 5'h0a);
    fchk(DA, 8'h7f, -1, 1'b0, 5'h15, 5'h0a);
    fchk(DA ^ 8'h80, 8'h81, -1, 1'b0, 5'h15, 5'h0a);
    fchk(DA ^ 8'h01, 8'hc1, -1, 1'b0, 5'h15, 5'h0a);
    fchk(DA, 8'h1f, -1, 1'b0, 5'h1f, 5'h0a);
    axi_rd(opvs_pkg::OFF_STATUS, 32'hf, 32'h5, opvs_pkg::RESP_OKAY);
    axi_rd(opvs_pkg::OFF_CONV2, 32'h1f, 32'h0a, opvs_pkg::RESP_OKAY);
    axi_wr(opvs_pkg::OFF_CTRL, 32'h0, opvs_pkg::RESP_OKAY);
    axi_rd(opvs_pkg::OFF_CTRL, 32'h1, 32'h0, opvs_pkg::RESP_OKAY);
    fchk(DA, 8'hc3, -1, 1'b0, 5'h1f, 5'h0a);
    axi_wr(opvs_pkg::OFF_CTRL, 32'h1, opvs_pkg::RESP_OKAY);
    fchk(DA, 8'h81, 3, 1'b0, 5'h1f, 5'h0a);
    // Long low: power-save only once the timeout has run out
    m.seg(1'b1, TO * TD - 40);
    chk("pwm_early", 32'(force_pwm), 32'h1);
    m.seg(1'b1, 60);
    chk("pwm_timeout", 32'(force_pwm), 32'h0);
    axi_rd(opvs_pkg::OFF_STATUS, 32'h1, 32'h0, opvs_pkg::RESP_OKAY);
    m.seg(1'b0, 4);
    chk("pwm_high", 32'(force_pwm), 32'h1);
    // Mode-change fall right before a frame shifts every bit
    m.seg(1'b1, 20);
    m.seg(1'b0, 4);
    fchk(DA, 8'hc7, -1, 1'b0, 5'h1f, 5'h0a);
    chk("pwm_in_frame", 32'(pwm_drop), 32'h0);
    chk("ack_open_drain", 32'(od_bad), 32'h0);
    results();
  end

  // Watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (50000) @(posedge clk);
    n_mismatch++;
    results();
  end
endmodule : opvs_core_tb_top
